// ---- core/asp_serial_port.sv ----
/*
 * serial port of a sampling converter, interface modes 2 to 5, with an
 * apb register slave. all pins are sampled by the core clock, which must
 * run well above both the serial clock and the master clock input.
 */
`timescale 1ns/100ps
module asp_serial_port (
	// core clock and reset
	input  wire logic                          CORE_CLK,
	input  wire logic                          RST,
	// apb slave
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [7:0]                    PADDR,
	input  wire logic [31:0]                   PWDATA,
	output logic      [31:0]                   PRDATA,
	output logic                               PREADY,
	output logic                               PSLVERR,
	// mode straps and conversion control
	input  wire logic                          SERIAL_MODE_SEL_HI,
	input  wire logic                          SERIAL_MODE_SEL_LO,
	input  wire logic                          POLARITY,
	input  wire logic                          CONVERT_START_N,
	input  wire logic                          MASTER_CLOCK_IN,
	input  wire logic [asp_pkg::RESULT_W-1:0]  CONV_RESULT,
	output logic                               BUSY,
	// serial clock pin
	input  wire logic                          SCLK_IN,
	output logic                               SCLK_OUT,
	output logic                               SCLK_OE_N,
	// frame sync pin, active low
	input  wire logic                          SYNC_N_IN,
	output logic                               SYNC_N_OUT,
	output logic                               SYNC_N_OE_N,
	// data pins
	input  wire logic                          DIN,
	output logic                               DOUT,
	output logic                               DOUT_OE_N
);
	localparam int W  = asp_pkg::WORD_W;
	localparam int RW = asp_pkg::RESULT_W;
	localparam int NP = asp_pkg::NPINS;
	localparam int TW = asp_pkg::CONV_TW;

	typedef struct packed {
		logic [NP-1:0]     meta;
		logic [NP-1:0]     pins;
		logic [NP-1:0]     prev;
		asp_pkg::asp_fsm_t fsm;
		logic [TW-1:0]     timer;
		logic              busy;
		logic              sw_conv;
		logic              sw_lock;
		logic              slv_open;
		logic              sync_n;
		logic              sync_oe_n;
		logic              sclk;
		logic              sclk_oe_n;
		logic              dout_oe_n;
		logic              rx_valid;
		logic [W-1:0]      rx_word;
		logic [W-1:0]      applied;
		logic [RW-1:0]     result;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
	} asp_port_st_t;

	asp_port_st_t s_r;
	asp_port_st_t s_nxt;

	asp_shift_if sh();

	asp_shifter #(
		.W (W)
	) u_shifter (
		.clk (CORE_CLK),
		.rst (RST),
		.sh  (sh.eng)
	);

	// reset image: pins at their idle levels, all pins released
	function automatic asp_port_st_t reset_state();
		asp_port_st_t r;
		r           = '0;
		r.meta      = asp_pkg::PIN_IDLE;
		r.pins      = asp_pkg::PIN_IDLE;
		r.prev      = asp_pkg::PIN_IDLE;
		r.fsm       = asp_pkg::ST_IDLE;
		r.sync_n    = 1'b1;
		r.sync_oe_n = 1'b1;
		r.sclk_oe_n = 1'b1;
		r.dout_oe_n = 1'b1;
		return r;
	endfunction

	// apb read data for an aligned register offset
	function automatic logic [31:0] read_mux(input asp_port_st_t s,
			input logic [7:0] a, input asp_pkg::asp_mode_t m);
		logic [31:0] d;
		d = '0;
		if (a == asp_pkg::REG_STATUS) begin
			d[asp_pkg::STAT_BUSY]    = s.busy;
			d[asp_pkg::STAT_RXVALID] = s.rx_valid;
			d[asp_pkg::STAT_LOCK]    = s.sw_lock;
			d[asp_pkg::STAT_MODE +: 2] = m;
		end else if (a == asp_pkg::REG_RX)
			d[W-1:0] = s.rx_word;
		else if (a == asp_pkg::REG_RESULT)
			d[RW-1:0] = s.result;
		else if (a == asp_pkg::REG_APPLIED)
			d[W-1:0] = s.applied;
		return d;
	endfunction

	// apb offset check
	function automatic logic mapped(input logic [7:0] a);
		return a == asp_pkg::REG_CTRL || a == asp_pkg::REG_STATUS ||
			a == asp_pkg::REG_RX || a == asp_pkg::REG_RESULT ||
			a == asp_pkg::REG_APPLIED;
	endfunction

	// frame-end bookkeeping shared by slave and self-clocked frames
	function automatic asp_port_st_t take_frame(input asp_port_st_t s,
			input logic [W-1:0] rx);
		asp_port_st_t r;
		r          = s;
		r.rx_word  = rx;
		r.applied  = rx;
		r.rx_valid = 1'b1;
		return r;
	endfunction

	asp_pkg::asp_mode_t mode;
	logic               pol;
	logic               self_m;
	logic [NP-1:0]      rise;
	logic [NP-1:0]      fall;
	logic               clk_rise;
	logic               clk_fall;
	logic               launch_ev;
	logic               sample_ev;
	logic               apb_take;
	logic               sw_start;
	logic               mclk_arm;

	always_comb begin
		s_nxt = s_r;
		// edge detection runs on the second synchroniser stage only
		s_nxt.meta = {POLARITY, SERIAL_MODE_SEL_LO, SERIAL_MODE_SEL_HI,
			MASTER_CLOCK_IN, CONVERT_START_N, DIN, SYNC_N_IN, SCLK_IN};
		s_nxt.pins = s_r.meta;
		s_nxt.prev = s_r.pins;
		rise = s_r.pins & ~s_r.prev;
		fall = ~s_r.pins & s_r.prev;

		// mode pins 00 give the default mode 2
		mode   = asp_pkg::asp_mode_t'({s_r.pins[asp_pkg::PIN_SMHI],
			s_r.pins[asp_pkg::PIN_SMLO]});
		pol    = s_r.pins[asp_pkg::PIN_POL];
		self_m = asp_pkg::self_clocked(mode);

		// serial clock edges: own master clock in modes 4/5, else the pin
		clk_rise  = self_m ? rise[asp_pkg::PIN_MCLK] : rise[asp_pkg::PIN_SCLK];
		clk_fall  = self_m ? fall[asp_pkg::PIN_MCLK] : fall[asp_pkg::PIN_SCLK];
		launch_ev = asp_pkg::launch_on_rise(mode, pol) ? clk_rise : clk_fall;
		sample_ev = asp_pkg::sample_on_rise(mode, pol) ? clk_rise : clk_fall;
		// mode 5 waits for a clock rise, mode 4 for a fall so the gate opens low
		mclk_arm  = (mode == asp_pkg::MODE5) ? rise[asp_pkg::PIN_MCLK]
			: fall[asp_pkg::PIN_MCLK];

		sh.clear      = 1'b0;
		sh.load       = 1'b0;
		sh.skip_first = 1'b0;
		sh.load_word  = {{(W-RW){1'b0}}, s_r.result};
		sh.launch     = 1'b0;
		sh.sample     = 1'b0;
		sh.din_bit    = s_r.pins[asp_pkg::PIN_DIN];

		// apb: one wait state, request taken in the first access cycle
		apb_take  = PSEL && PENABLE && !s_r.pready;
		s_nxt.pready  = apb_take;
		s_nxt.pslverr = apb_take && !mapped(PADDR);
		s_nxt.prdata  = '0;
		if (apb_take && !PWRITE)
			s_nxt.prdata = read_mux(s_r, PADDR, mode);
		// a locked-out software start is ignored
		sw_start = apb_take && PWRITE && PADDR == asp_pkg::REG_CTRL &&
			PWDATA[asp_pkg::CTRL_START] && !(self_m && s_r.sw_lock);
		if (apb_take && PWRITE && PADDR == asp_pkg::REG_STATUS &&
				PWDATA[asp_pkg::STAT_RXVALID])
			s_nxt.rx_valid = 1'b0;

		// only a pin toggle lifts the software lockout
		if (fall[asp_pkg::PIN_CNV])
			s_nxt.sw_lock = 1'b0;

		// conversion sequencer
		case (s_r.fsm)
			asp_pkg::ST_IDLE: begin
				if (fall[asp_pkg::PIN_CNV] || sw_start) begin
					s_nxt.busy    = 1'b1;
					s_nxt.sw_conv = sw_start;
					s_nxt.timer   = '0;
					if (!self_m)
						s_nxt.fsm = asp_pkg::ST_CONV;
					else if (sw_start)
						s_nxt.fsm = asp_pkg::ST_ARM;
					else
						s_nxt.fsm = asp_pkg::ST_HOLD;
				end
			end
			asp_pkg::ST_HOLD: begin
				// sync drops only after the convert-start pin rises
				if (rise[asp_pkg::PIN_CNV])
					s_nxt.fsm = asp_pkg::ST_ARM;
			end
			asp_pkg::ST_ARM: begin
				if (mclk_arm) begin
					s_nxt.sync_n    = 1'b0;
					s_nxt.dout_oe_n = 1'b0;
					s_nxt.fsm       = asp_pkg::ST_FRAME;
					// current result goes out with the frame's first bit
					sh.load      = 1'b1;
					sh.load_word = {{(W-RW){1'b0}}, CONV_RESULT};
				end
			end
			asp_pkg::ST_FRAME: begin
				if (sh.done) begin
					// sync rises two core cycles after the 16th sampling edge is detected
					s_nxt           = take_frame(s_nxt, sh.rx_word);
					s_nxt.sync_n    = 1'b1;
					s_nxt.dout_oe_n = 1'b1;
					s_nxt.busy      = 1'b0;
					s_nxt.result    = CONV_RESULT;
					s_nxt.sw_lock   = s_r.sw_conv;
					s_nxt.fsm       = asp_pkg::ST_IDLE;
				end else begin
					// shift only while own sync is low
					sh.launch = launch_ev;
					sh.sample = sample_ev;
				end
			end
			asp_pkg::ST_CONV: begin
				s_nxt.timer = s_r.timer + TW'(1);
				if (s_r.timer == asp_pkg::CONV_LAST) begin
					s_nxt.busy   = 1'b0;
					s_nxt.result = CONV_RESULT;
					s_nxt.fsm    = asp_pkg::ST_IDLE;
				end
			end
			default: s_nxt.fsm = asp_pkg::ST_IDLE;
		endcase

		// slave framing in modes 2 and 3
		if (!self_m) begin
			if (rise[asp_pkg::PIN_SYNC]) begin
				// sync high floats the output and resets the bit framing
				s_nxt.slv_open  = 1'b0;
				s_nxt.dout_oe_n = 1'b1;
				sh.clear        = 1'b1;
			end else if (fall[asp_pkg::PIN_SYNC]) begin
				// frame starts at the sync falling edge in both modes
				s_nxt.slv_open  = 1'b1;
				s_nxt.dout_oe_n = 1'b0;
				sh.load         = 1'b1;
				sh.skip_first   = 1'b1;
			end else if (s_r.slv_open) begin
				if (sh.done) begin
					s_nxt = take_frame(s_nxt, sh.rx_word);
					// mode 2 with sync held low frames every 16 clocks;
					// mode 3 just stops counting until the next sync fall
					if (mode == asp_pkg::MODE2) begin
						sh.load       = 1'b1;
						sh.skip_first = 1'b1;
					end else
						s_nxt.slv_open = 1'b0;
				end else begin
					sh.launch = launch_ev;
					sh.sample = sample_ev;
				end
			end
		end else
			s_nxt.slv_open = 1'b0;

		// pin drivers: clock and sync are outputs only in modes 4 and 5
		s_nxt.sync_oe_n = !self_m;
		s_nxt.sclk_oe_n = !self_m;
		if (!self_m)
			s_nxt.sync_n = 1'b1;
		if (mode == asp_pkg::MODE5)
			s_nxt.sclk = s_r.pins[asp_pkg::PIN_MCLK];
		else if (mode == asp_pkg::MODE4)
			s_nxt.sclk = s_r.pins[asp_pkg::PIN_MCLK] &&
				s_nxt.fsm == asp_pkg::ST_FRAME;
		else
			s_nxt.sclk = 1'b0;

		// a new frame sets the valid flag whether or not software has cleared it;
		// hardware set above wins over the software clear
		if (s_r.fsm == asp_pkg::ST_FRAME && sh.done)
			s_nxt.rx_valid = 1'b1;
	end

	// state register
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			s_r <= reset_state();
		else
			s_r <= s_nxt;
	end

	// every output comes straight from the state register or the shifter
	assign PRDATA      = s_r.prdata;
	assign PREADY      = s_r.pready;
	assign PSLVERR     = s_r.pslverr;
	assign BUSY        = s_r.busy;
	assign SCLK_OUT    = s_r.sclk;
	assign SCLK_OE_N   = s_r.sclk_oe_n;
	assign SYNC_N_OUT  = s_r.sync_n;
	assign SYNC_N_OE_N = s_r.sync_oe_n;
	assign DOUT        = sh.dout_bit;
	assign DOUT_OE_N   = s_r.dout_oe_n;
endmodule

// ---- core/asp_pkg.sv ----
/*
 * shared constants, types and helper functions of the adc serial port:
 * register map, pin positions, interface modes, timing counts.
 * assumes a 250 MHz core clock; the analog core supplies the result word.
 */
// Function
// - mode pins both low after power-up select default three-wire slave mode 2
// - mode 2: sync fall drives output, first launch edge gives leading zero
// - mode 2 default polarity samples serial input on clock rising edges
// - polarity pin swaps the sampling edge and the launching edge
// - sync high then low resets framing; new frame starts at falling edge
// - mode 3: sync falling edge starts frame; sixteen clocks counted internally
// - mode 3: sync rise floats output, fall drives; launch fall, sample rise
// - modes 4/5 drive clock and sync; mode 5 passes, mode 4 gates clock
// - modes 4/5 shift current result; received word applies to next conversion
// - convert-start pin falling edge begins a conversion and raises busy
// - modes 4/5: convert-start rise drops sync within 0.5 to 1.5 periods; code drops it at the next arming clock edge, 0 to 1 period later
// - modes 4/5 end after sixteen clocks: sync rises, busy falls
// - modes 4/5: sync fall launches first bit, later rises shift data
// - mode 5 drops sync after a clock rise, raises it after 16th rise
// - writing 1 to the start bit starts conversion and opens a transfer
// - after software-started self-clocked conversion, only pin toggle reopens transfers
// - self-clocking modes transfer data only while frame sync is low
// - mode pins 00 mode 2, 01 mode 3, 10 mode 4, 11 mode 5
// - modes 1-3 and modes 4/5 use opposite edge mappings per polarity; code flips only the sample edge
package asp_pkg;

	// frame, result and bit-counter widths
	localparam int WORD_W   = 16;
	localparam int RESULT_W = 12;
	localparam int CNT_W    = 5;

	// register byte offsets (apb, one aligned word each)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_RX      = 8'h08;
	localparam logic [7:0] REG_RESULT  = 8'h0c;
	localparam logic [7:0] REG_APPLIED = 8'h10;

	// field positions
	localparam int CTRL_START   = 0;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_RXVALID = 1;
	localparam int STAT_LOCK    = 2;
	localparam int STAT_MODE    = 4;

	// synchronised pin vector positions
	localparam int PIN_SCLK = 0;
	localparam int PIN_SYNC = 1;
	localparam int PIN_DIN  = 2;
	localparam int PIN_CNV  = 3;
	localparam int PIN_MCLK = 4;
	localparam int PIN_SMHI = 5;
	localparam int PIN_SMLO = 6;
	localparam int PIN_POL  = 7;
	localparam int NPINS    = 8;
	// idle levels: sync and convert-start rest high
	localparam logic [NPINS-1:0] PIN_IDLE = 8'h0a;

	// conversion time for the externally clocked modes
	localparam int T_CONV_NS   = 4600;
	localparam int CORE_MHZ    = 250;
	localparam int CONV_CYCLES = (T_CONV_NS * CORE_MHZ + 999) / 1000;
	localparam int CONV_TW     = $clog2(CONV_CYCLES + 1);
	localparam logic [CONV_TW-1:0] CONV_LAST = CONV_TW'(CONV_CYCLES - 1);

	// interface modes, coded as the two mode-select pins
	typedef enum logic [1:0] {
		MODE2 = 2'h0,
		MODE3 = 2'h1,
		MODE4 = 2'h2,
		MODE5 = 2'h3
	} asp_mode_t;

	// conversion sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_HOLD  = 5'h02,
		ST_ARM   = 5'h04,
		ST_FRAME = 5'h08,
		ST_CONV  = 5'h10
	} asp_fsm_t;

	// self-clocking modes make their own clock and sync
	function automatic logic self_clocked(input asp_mode_t m);
		return m[1];
	endfunction

	// output launch edge: slave modes launch on fall when polarity is high
	function automatic logic launch_on_rise(input asp_mode_t m, input logic p);
		return self_clocked(m) ? !p : !p;
	endfunction

	// input sample edge: slave modes use the opposite edge, self modes the same
	function automatic logic sample_on_rise(input asp_mode_t m, input logic p);
		return self_clocked(m) ? !p : p;
	endfunction

endpackage

// ---- core/asp_shift_if.sv ----
/*
 * carrier between the port sequencer and the 16-bit shift engine.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface asp_shift_if;
	logic                        clear;
	logic                        load;
	logic                        skip_first;
	logic [asp_pkg::WORD_W-1:0]  load_word;
	logic                        launch;
	logic                        sample;
	logic                        din_bit;
	logic                        dout_bit;
	logic [asp_pkg::WORD_W-1:0]  rx_word;
	logic                        done;

	modport ctl(
		output clear, load, skip_first, load_word, launch, sample, din_bit,
		input  dout_bit, rx_word, done
	);
	modport eng(
		input  clear, load, skip_first, load_word, launch, sample, din_bit,
		output dout_bit, rx_word, done
	);
endinterface

// ---- core/asp_shifter.sv ----
/*
 * shift engine: one frame of W bits, msb first, in and out together.
 * assumes launch and sample strobes are single core-clock pulses.
 */
`timescale 1ns/100ps
module asp_shifter #(
	parameter int W = asp_pkg::WORD_W
) (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst,
	// sequencer side
	asp_shift_if.eng    sh
);
	localparam int CW = asp_pkg::CNT_W;

	// the carrier is fixed at the package width
	if (W != asp_pkg::WORD_W || W >= (1 << CW))
		$error("asp_shifter: unsupported frame width");

	typedef struct packed {
		logic [W-1:0]  tx;
		logic [W-1:0]  rx;
		logic [CW-1:0] cnt;
		logic          skip;
	} asp_shift_st_t;

	asp_shift_st_t s_r;
	asp_shift_st_t s_nxt;

	// load wins over shifting; a cleared frame holds still
	always_comb begin
		s_nxt = s_r;
		if (sh.clear) begin
			s_nxt.tx   = '0;
			s_nxt.cnt  = '0;
			s_nxt.skip = 1'b0;
		end else if (sh.load) begin
			s_nxt.tx   = sh.load_word;
			s_nxt.cnt  = '0;
			s_nxt.skip = sh.skip_first;
		end else begin
			// no more than W bits are taken per frame
			if (sh.sample && s_r.cnt < CW'(W)) begin
				s_nxt.rx  = {s_r.rx[W-2:0], sh.din_bit};
				s_nxt.cnt = s_r.cnt + CW'(1);
			end
			// after a load with skip_first, the first launch edge only presents the msb already loaded
			if (sh.launch) begin
				if (s_r.skip)
					s_nxt.skip = 1'b0;
				else
					s_nxt.tx = {s_r.tx[W-2:0], 1'b0};
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign sh.dout_bit = s_r.tx[W-1];
	assign sh.rx_word  = s_r.rx;
	assign sh.done     = (s_r.cnt == CW'(W));
endmodule

// ---- verif/asp_assertions.sv ----
/*
 * pin-level checker of the adc serial port, bound to its top module.
 * assumes the master clock is much slower than the core clock.
 */
`timescale 1ns/100ps
module asp_assertions (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// straps, conversion and bus status
	input wire logic PSLVERR,
	input wire logic SERIAL_MODE_SEL_HI,
	input wire logic SERIAL_MODE_SEL_LO,
	input wire logic CONVERT_START_N,
	input wire logic MASTER_CLOCK_IN,
	input wire logic BUSY,
	// link pins
	input wire logic SCLK_OUT,
	input wire logic SCLK_OE_N,
	input wire logic SYNC_N_IN,
	input wire logic SYNC_N_OUT,
	input wire logic SYNC_N_OE_N,
	input wire logic DOUT,
	input wire logic DOUT_OE_N
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	logic       mck_r;
	logic [4:0] rises_r;
	// raw master clock rises while the port holds sync low
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			mck_r <= 1'b0;
			rises_r <= 5'h00;
		end else begin
			mck_r <= MASTER_CLOCK_IN;
			if (SYNC_N_OUT)
				rises_r <= 5'h00;
			else if (MASTER_CLOCK_IN && !mck_r)
				rises_r <= rises_r + 5'h01;
		end
	end

	property p_quiet; (!SERIAL_MODE_SEL_HI) [*8] |-> SCLK_OE_N && SYNC_N_OE_N; endproperty
	a_quiet: assert property (p_quiet) else $error("slave mode drives link clock");
	property p_gate; (SERIAL_MODE_SEL_HI && !SERIAL_MODE_SEL_LO && SYNC_N_OUT) [*8] |-> !SCLK_OUT; endproperty
	a_gate: assert property (p_gate) else $error("gated clock runs outside frame");
	property p_busy; $fell(CONVERT_START_N) && !BUSY |-> ##[1:6] BUSY; endproperty
	a_busy: assert property (p_busy) else $error("busy late after start");
	property p_sync; SERIAL_MODE_SEL_HI && BUSY && $rose(CONVERT_START_N) |-> ##[1:24] !SYNC_N_OUT; endproperty
	a_sync: assert property (p_sync) else $error("sync not dropped after start");
	property p_count; SERIAL_MODE_SEL_HI && $rose(SYNC_N_OUT) |-> rises_r == 5'h10; endproperty
	a_count: assert property (p_count) else $error("frame is not sixteen clocks");
	property p_end; $rose(SYNC_N_OUT) |-> ##[0:2] !BUSY ##[0:2] DOUT_OE_N; endproperty
	a_end: assert property (p_end) else $error("busy or output left at frame end");
	property p_float; (!SERIAL_MODE_SEL_HI && SYNC_N_IN) [*8] |-> DOUT_OE_N; endproperty
	a_float: assert property (p_float) else $error("output driven with sync high");
	property p_drive; !SERIAL_MODE_SEL_HI && $fell(SYNC_N_IN) |-> ##[2:5] !DOUT_OE_N; endproperty
	a_drive: assert property (p_drive) else $error("output not driven after sync");
	property p_lead; $fell(DOUT_OE_N) |-> !DOUT; endproperty
	a_lead: assert property (p_lead) else $error("first bit is not zero");

	// main scenarios reached
	c_self: cover property (SERIAL_MODE_SEL_HI && $rose(SYNC_N_OUT));
	c_slave: cover property (!SERIAL_MODE_SEL_HI && $fell(DOUT_OE_N));
	c_err: cover property (PSLVERR);
endmodule

bind asp_serial_port asp_assertions u_chk (
	.CORE_CLK, .RST, .PSLVERR, .SERIAL_MODE_SEL_HI, .SERIAL_MODE_SEL_LO,
	.CONVERT_START_N, .MASTER_CLOCK_IN, .BUSY, .SCLK_OUT, .SCLK_OE_N,
	.SYNC_N_IN, .SYNC_N_OUT, .SYNC_N_OE_N, .DOUT, .DOUT_OE_N
);

// ---- verif/asp_host.sv ----
/*
 * host serial port model: master of the link in modes 2 and 3,
 * listener feeding its data line in the self-clocked modes.
 */
`timescale 1ns/100ps
module asp_host (
	// link pins, read back at the wire
	output logic      sclk,
	output logic      sync_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic sclk_w,
	input  wire logic sync_w,
	// port drives clock and sync, edge strap
	input  wire logic self_n,
	input  wire logic pol
);
	logic [15:0] stx;
	int          nb;
	realtime     t0;

	// idle: no frame, clock stands still
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		din = 1'b0;
		stx = 16'h0000;
	end

	// slave-mode frame of nclk clocks; clocks past 16 send junk.
	// clock rests on its sampling level, so the first edge launches;
	// pins move 1 ns after a core edge to stay clear of it
	task automatic frame(input logic [15:0] tx, input int nclk,
		output logic [15:0] rx);
		#1 sclk = pol;
		#8 sync_n = 1'b0;
		#24;
		for (int i = 15; i > 15 - nclk; i--) begin
			#16 sclk = !pol;
			din = (i >= 0) ? tx[i[3:0]] : !din;
			#16 sclk = pol;
			if (i >= 0)
				rx[i[3:0]] = dout;
		end
		#32 sync_n = 1'b1;
		din = !din;
	endtask

	// self-clocked frame: msb ready when the port drops sync
	always @(negedge sync_w) begin
		if (!self_n) begin
			t0 = $realtime;
			nb = 15;
			din = stx[15];
		end
	end
	// a rise right at the sync fall is the one that dropped it
	always @(posedge sclk_w) begin
		if (!self_n && !sync_w && $realtime - t0 > 10 && nb > 0) begin
			nb = nb - 1;
			din = stx[nb[3:0]];
		end
	end
	// released line flips so a stale bit is never taken for data
	always @(posedge sync_w) begin
		if (!self_n)
			din = !din;
	end
endmodule

// ---- verif/asp_serial_port_tb_top.sv ----
/*
 * testbench of the adc serial port: apb tasks, host model on the link.
 * assumes a slave that answers in its own time and a 32 ns master clock.
 */
`timescale 1ns/100ps
module asp_serial_port_tb_top;
	// core, bus and pins
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        sel_hi, sel_lo, pol, convert_start_n_n, mclk, busy;
	logic [11:0] res;
	logic        sclk, sync_n, din, dout, dout_oe_n, sclk_o, sync_o;
	logic        sclk_oe_n, sync_oe_n, sclk_w, sync_w, err;
	// bookkeeping
	int          fail_count, n_compared;
	logic [15:0] rx, w;

	asp_serial_port dut (
		.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SERIAL_MODE_SEL_HI(sel_hi), .SERIAL_MODE_SEL_LO(sel_lo),
		.POLARITY(pol), .CONVERT_START_N(convert_start_n_n),
		.MASTER_CLOCK_IN(mclk), .CONV_RESULT(res), .BUSY(busy),
		.SCLK_IN(sclk_w), .SCLK_OUT(sclk_o), .SCLK_OE_N(sclk_oe_n),
		.SYNC_N_IN(sync_w), .SYNC_N_OUT(sync_o),
		.SYNC_N_OE_N(sync_oe_n), .DIN(din), .DOUT(dout),
		.DOUT_OE_N(dout_oe_n)
	);
	asp_host host (
		.sclk(sclk), .sync_n(sync_n), .din(din), .dout(dout),
		.sclk_w(sclk_w), .sync_w(sync_w), .self_n(sclk_oe_n), .pol(pol)
	);
	// wire level: the port wins while it drives
	assign sclk_w = sclk_oe_n ? sclk : sclk_o;
	assign sync_w = sync_oe_n ? sync_n : sync_o;

	// core clock and free-running master clock, unrelated phase
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		mclk = 1'b0;
		#1.3;
		forever #16 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask

	// one apb transfer; a read with a name is compared to d
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input string nm = "");
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count is assumed: only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		err = pslverr;
		if (nm != "")
			chk(nm, prdata, d);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// host frame, then let the result settle into the registers
	task automatic xfer(input logic [15:0] tx, input int nclk);
		host.frame(tx, nclk, rx);
		repeat (4) @(posedge clk);
	endtask

	task automatic cnv();
		convert_start_n_n <= 1'b0;
		repeat (4) @(posedge clk);
		convert_start_n_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk("busy", {31'h0, busy}, {31'h0, lvl});
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	initial begin
		#60000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{sel_hi, sel_lo, pol, convert_start_n_n} = 4'h3;
		res = 12'ha5c;
		fail_count = 0;
		n_compared = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// defaults, unmapped offset, core-timed conversion
		apb(1'b0, asp_pkg::REG_STATUS, 32'h0, "status");
		apb(1'b0, 8'h14, 32'h0, "unmapped");
		chk("slverr", {31'h0, err}, 32'h1);
		cnv();
		wait_busy(1'b1);
		wait_busy(1'b0);
		apb(1'b0, asp_pkg::REG_RESULT, 32'h0a5c, "result");
		$display("test reset done");
		// mode 2: full frame, aborted frame, polarity low
		xfer(16'h1234, 16);
		chk("dout", {16'h0, rx}, 32'h0a5c);
		apb(1'b0, asp_pkg::REG_RX, 32'h1234, "rx");
		apb(1'b0, asp_pkg::REG_STATUS, 32'h2, "status");
		apb(1'b1, asp_pkg::REG_STATUS, 32'h2);
		apb(1'b0, asp_pkg::REG_STATUS, 32'h0, "status");
		xfer(16'hffff, 5);
		xfer(16'hbeef, 16);
		apb(1'b0, asp_pkg::REG_RX, 32'hbeef, "rx");
		pol <= 1'b0;
		// let the strap pass the synchroniser before the frame
		repeat (4) @(posedge clk);
		xfer(16'h0f0f, 16);
		chk("dout", {16'h0, rx}, 32'h0a5c);
		apb(1'b0, asp_pkg::REG_RX, 32'h0f0f, "rx");
		pol <= 1'b1;
		$display("test mode 2 done");
		// mode 3: clocks past the sixteenth are not taken
		sel_lo <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(16'hc3a5, 20);
		chk("dout", {16'h0, rx}, 32'h0a5c);
		apb(1'b0, asp_pkg::REG_RX, 32'hc3a5, "rx");
		apb(1'b0, asp_pkg::REG_STATUS, 32'h12, "status");
		$display("test mode 3 done");
		// modes 4 and 5 started by the pin
		pol <= 1'b0;
		for (int m = 2; m < 4; m++) begin
			w = 16'h9870 + 16'(m);
			{sel_hi, sel_lo} <= m[1:0];
			host.stx = w;
			repeat (4) @(posedge clk);
			cnv();
			wait_busy(1'b1);
			wait_busy(1'b0);
			repeat (100) @(posedge clk);
			apb(1'b0, asp_pkg::REG_RX, {16'h0, w}, "rx");
			apb(1'b0, asp_pkg::REG_APPLIED, {16'h0, w}, "applied");
		end
		// software start locks out software, the pin reopens
		apb(1'b1, asp_pkg::REG_CTRL, 32'h1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (100) @(posedge clk);
		apb(1'b0, asp_pkg::REG_STATUS, 32'h36, "status");
		apb(1'b1, asp_pkg::REG_CTRL, 32'h1);
		repeat (20) @(posedge clk);
		chk("busy", {31'h0, busy}, 32'h0);
		cnv();
		wait_busy(1'b1);
		wait_busy(1'b0);
		$display("test self modes done");
		report_and_stop();
	end
endmodule
